// *** common/sgfb_pkg.sv ***
// constants for the framebuffer memory command sequencer
// assumes one clock shared with the memory chips, rising-edge signalling
// Contract
// - bus is 64-bit/2MB or 128-bit/4MB
// - every access opens with row activate
// - column address comes with read or write
// - single-beat accesses, one per clock possible
// - everything launched and sampled on rising edges
// - inhibit, nop, load-mode encodings; opcode in addr[8:0]
// - activate encoding, bank addr[9], row addr[8:0]
// - read encoding, bank, addr[8] zero, column
// - write encoding with valid data same cycle
// - precharge encoding, addr[8] high closes both
// - mask low enables, write zero-, read two-delay; code sends the read mask with the read command
// - clock enable high, special function low always
// - first command on first edge after reset
// - initialisation starts with all-bank precharge
// - mode load before any read or write
// - mode burst-length field zero
// - read latency two or three, sampled accordingly
// - three clocks from activate to read/write
`default_nettype none
package sgfb_pkg;
    localparam int DATA_W = 128;
    localparam int NARROW_W = 64;
    localparam int MASK_W = 16;
    localparam int ADDR_W = 10;
    localparam int ROW_W = 9;
    localparam int COL_W = 8;
    localparam int BANK_BIT = 9;
    localparam int PRE_ALL_BIT = 8;
    // {row strobe, column strobe, write strobe}, all active low
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_LMR = 3'h0;
    // waits, already in memory clocks
    localparam logic [3:0] T_RCD_CK = 4'h3;
    localparam logic [3:0] T_RP_CK = 4'h4;
    localparam logic [3:0] T_RAS_CK = 4'h7;
    localparam logic [3:0] T_WR_CK = 4'h2;
    localparam logic [3:0] T_MRD_CK = 4'h2;
    localparam logic [3:0] CNT_SAT = 4'hF;
    // mode word fields
    localparam logic [2:0] MODE_BL_ONE = 3'h0;
    localparam logic [2:0] MODE_LAT_TWO = 3'h2;
    localparam logic [2:0] MODE_LAT_THREE = 3'h3;
    // values after reset, chip-select patterns and the narrow-bus mask
    localparam logic [ADDR_W-1:0] RST_ADDR = 10'h000;
    localparam logic [MASK_W-1:0] RST_MASK = 16'hFFFF;
    localparam logic [1:0] RST_CS = 2'h3;
    localparam logic [1:0] CS_WIDE = 2'h0;
    localparam logic [1:0] CS_NARROW = 2'h2;
    localparam logic [MASK_W-1:0] MASK_NARROW_OFF = 16'hFF00;
    localparam logic [3:0] RST_CNT = 4'h0;
endpackage
`default_nettype wire

// *** common/sgfb_if.sv ***
// carrier between the sequencer and its init and read-return helpers
// assumes all three modules run on the same clock
`default_nettype none
interface sgfb_if;
    logic [2:0] init_cmd;
    logic [9:0] init_addr;
    logic init_done;
    logic lat3;
    logic rd_issue;
    logic rd_capture;
    modport init_mp (input lat3, output init_cmd, output init_addr, output init_done);
    modport rd_mp (input lat3, input rd_issue, output rd_capture);
    modport main_mp (input init_cmd, input init_addr, input init_done, input rd_capture,
        output lat3, output rd_issue);
endinterface
`default_nettype wire

// *** hdl/sgfb_init.sv ***
// power-up sequence: precharge all, wait, load mode, wait
// assumes the sequencer forwards init_cmd while init_done is low
`default_nettype none
module sgfb_init
    import sgfb_pkg::*;
(
    input wire logic sys_clk, // memory clock
    input wire logic rst, // sync reset, high
    sgfb_if.init_mp lnk // init command side
);
    typedef enum logic [4:0] {
        IN_PRE = 5'b00001,
        IN_RP = 5'b00010,
        IN_LMR = 5'b00100,
        IN_MRD = 5'b01000,
        IN_DONE = 5'b10000
    } sgfb_init_state_type;
    sgfb_init_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d;

    // sequence steps; precharge comes first out of reset
    always_comb
    begin
        st_d = st_q;
        cnt_d = (cnt_q == RST_CNT) ? RST_CNT : cnt_q - 4'h1;
        lnk.init_cmd = CMD_NOP;
        lnk.init_addr = RST_ADDR;
        case (st_q)
            IN_PRE:
            begin
                lnk.init_cmd = CMD_PRE;
                lnk.init_addr[PRE_ALL_BIT] = 1'b1;
                cnt_d = T_RP_CK - 4'h1;
                st_d = IN_RP;
            end
            IN_RP:
                if (cnt_q == RST_CNT)
                    st_d = IN_LMR;
            IN_LMR:
            begin
                lnk.init_cmd = CMD_LMR;
                // opcode: burst length one, latency two or three
                lnk.init_addr = {3'h0, lnk.lat3 ? MODE_LAT_THREE : MODE_LAT_TWO, 1'b0,
                    MODE_BL_ONE};
                cnt_d = T_MRD_CK - 4'h1;
                st_d = IN_MRD;
            end
            IN_MRD:
                if (cnt_q == RST_CNT)
                    st_d = IN_DONE;
            IN_DONE: st_d = IN_DONE;
            default: st_d = IN_PRE;
        endcase
    end

    assign lnk.init_done = (st_q == IN_DONE);

    // registers only
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= IN_PRE;
            cnt_q <= RST_CNT;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// *** hdl/sgfb_rdpipe.sv ***
// read-return timer: flags the edge at which read data is on the pins
// assumes rd_issue is the registered read command seen by the memory
`default_nettype none
module sgfb_rdpipe
    import sgfb_pkg::*;
(
    input wire logic sys_clk, // memory clock
    input wire logic rst, // sync reset, high
    sgfb_if.rd_mp lnk // issue in, capture out
);
    logic [2:0] sh_q, sh_d;

    // the chips register the read one edge after launch, so latency
    // counts from there; tapping one stage early would take stale data
    always_comb
    begin
        sh_d = {sh_q[1:0], lnk.rd_issue};
    end

    assign lnk.rd_capture = lnk.lat3 ? sh_q[2] : sh_q[1];

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            sh_q <= 3'h0;
        else
            sh_q <= sh_d;
    end
endmodule
`default_nettype wire

// *** hdl/sgfb_ctrl.sv ***
// framebuffer memory command sequencer, top level
// assumes memory chips clocked by sys_clk forwarded on mem_clock_out
// cfg straps are static and taken while rst is high
`default_nettype none
module sgfb_ctrl
    import sgfb_pkg::*;
(
    input wire logic sys_clk, // 40 MHz clock
    input wire logic rst, // sync reset, high
    input wire logic cfg_wide, // 1: 128-bit/4MB, 0: 64-bit/2MB
    input wire logic cfg_lat3, // 1: read latency three, 0: two
    input wire logic req_valid, // access request
    input wire logic req_write, // 1 write, 0 read
    input wire logic req_bank, // bank
    input wire logic [ROW_W-1:0] req_row, // row
    input wire logic [COL_W-1:0] req_col, // column
    input wire logic [DATA_W-1:0] req_wdata, // write data
    input wire logic [MASK_W-1:0] req_mask_n, // byte mask, low enables
    output logic req_ready, // request taken when valid and ready
    output logic rd_valid, // read data strobe
    output logic [DATA_W-1:0] rd_data, // read data
    output logic mem_ready, // initialisation finished
    output logic mem_clock_out, // forwarded memory clock
    output logic [1:0] mem_chip_select_n, // per chip pair
    output logic mem_row_strobe_n, // row strobe
    output logic mem_column_strobe_n, // column strobe
    output logic mem_write_strobe_n, // write strobe
    output logic [MASK_W-1:0] mem_byte_mask_n, // byte mask
    output logic [ADDR_W-1:0] mem_address, // address
    output logic [DATA_W-1:0] mem_data_out, // data to memory
    output logic mem_data_oe, // data bus driven
    input wire logic [DATA_W-1:0] mem_data_in, // data from memory
    output logic mem_clock_enable, // held high
    output logic special_function_select // held low
);
    typedef enum logic [5:0] {
        ST_INIT = 6'b000001,
        ST_IDLE = 6'b000010,
        ST_RCD = 6'b000100,
        ST_OPEN = 6'b001000,
        ST_PREW = 6'b010000,
        ST_RP = 6'b100000
    } sgfb_state_type;

    sgfb_if lnk ();

    sgfb_state_type st_q, st_d;
    logic [3:0] cnt_q, cnt_d, ras_q, ras_d, wrc_q, wrc_d;
    logic wide_q, wide_d, lat3_q, lat3_d;
    logic [2:0] cmd_q, cmd_d;
    logic [1:0] cs_q, cs_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [MASK_W-1:0] mask_q, mask_d;
    logic [DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic oe_q, oe_d, rdv_q, rdv_d, rdy_q, rdy_d, done_q, done_d;
    logic cke_q, dsf_q;
    logic pw_q, pw_d, pb_q, pb_d;
    logic [ROW_W-1:0] pr_q, pr_d;
    logic [COL_W-1:0] pc_q, pc_d;
    logic [DATA_W-1:0] pd_q, pd_d;
    logic [MASK_W-1:0] pm_q, pm_d;
    logic take, hit, pre_ok;

    sgfb_init u_init (
        .sys_clk(sys_clk),
        .rst(rst),
        .lnk(lnk.init_mp)
    );

    sgfb_rdpipe u_rdpipe (
        .sys_clk(sys_clk),
        .rst(rst),
        .lnk(lnk.rd_mp)
    );

    assign lnk.lat3 = lat3_q;
    assign lnk.rd_issue = (cmd_q == CMD_RD) && (cs_q != RST_CS);

    // the chips need the same edge we launch on; a divided copy would
    // halve bandwidth, so the clock itself is forwarded
    assign mem_clock_out = sys_clk;

    assign take = req_valid && rdy_q;
    assign hit = (req_bank == pb_q) && (req_row == pr_q);
    assign pre_ok = (ras_q >= T_RAS_CK - 4'h1) && (wrc_q >= T_WR_CK - 4'h1);

    // command sequencer: one command per clock at most
    always_comb
    begin
        st_d = st_q;
        cnt_d = (cnt_q == RST_CNT) ? RST_CNT : cnt_q - 4'h1;
        ras_d = (ras_q == CNT_SAT) ? CNT_SAT : ras_q + 4'h1;
        wrc_d = (wrc_q == CNT_SAT) ? CNT_SAT : wrc_q + 4'h1;
        wide_d = wide_q;
        lat3_d = lat3_q;
        cmd_d = CMD_NOP;
        cs_d = wide_q ? CS_WIDE : CS_NARROW;
        addr_d = addr_q;
        mask_d = mask_q;
        wdat_d = wdat_q;
        oe_d = 1'b0;
        rdy_d = 1'b0;
        done_d = lnk.init_done;
        pw_d = pw_q;
        pb_d = pb_q;
        pr_d = pr_q;
        pc_d = pc_q;
        pd_d = pd_q;
        pm_d = pm_q;
        // a miss or a closed row parks the request as pending
        if (take && !((st_q == ST_OPEN) && hit))
        begin
            pw_d = req_write;
            pb_d = req_bank;
            pr_d = req_row;
            pc_d = req_col;
            pd_d = req_wdata;
            pm_d = req_mask_n;
        end
        case (st_q)
            ST_INIT:
            begin
                cmd_d = lnk.init_cmd;
                addr_d = lnk.init_addr;
                if (lnk.init_done)
                begin
                    st_d = ST_IDLE;
                    rdy_d = 1'b1;
                end
            end
            ST_IDLE:
            begin
                rdy_d = 1'b1;
                if (take)
                begin
                    cmd_d = CMD_ACT;
                    addr_d = {req_bank, req_row};
                    ras_d = RST_CNT;
                    cnt_d = T_RCD_CK - 4'h1;
                    st_d = ST_RCD;
                    rdy_d = 1'b0;
                end
            end
            ST_RCD:
                if (cnt_q == RST_CNT)
                begin
                    cmd_d = pw_q ? CMD_WR : CMD_RD;
                    addr_d = {pb_q, 1'b0, pc_q};
                    mask_d = pm_q;
                    if (pw_q)
                    begin
                        wdat_d = pd_q;
                        oe_d = 1'b1;
                        wrc_d = RST_CNT;
                    end
                    st_d = ST_OPEN;
                    rdy_d = 1'b1;
                end
            ST_OPEN:
            begin
                rdy_d = 1'b1;
                if (take && hit)
                begin
                    // open row: issue at once, back to back allowed
                    cmd_d = req_write ? CMD_WR : CMD_RD;
                    addr_d = {req_bank, 1'b0, req_col};
                    mask_d = req_mask_n;
                    if (req_write)
                    begin
                        wdat_d = req_wdata;
                        oe_d = 1'b1;
                        wrc_d = RST_CNT;
                    end
                end
                else if (take)
                begin
                    rdy_d = 1'b0;
                    st_d = ST_PREW;
                    if (pre_ok)
                    begin
                        cmd_d = CMD_PRE;
                        addr_d[PRE_ALL_BIT] = 1'b1;
                        cnt_d = T_RP_CK - 4'h1;
                        st_d = ST_RP;
                    end
                end
            end
            ST_PREW:
                if (pre_ok)
                begin
                    cmd_d = CMD_PRE;
                    addr_d[PRE_ALL_BIT] = 1'b1;
                    cnt_d = T_RP_CK - 4'h1;
                    st_d = ST_RP;
                end
            ST_RP:
                if (cnt_q == RST_CNT)
                begin
                    cmd_d = CMD_ACT;
                    addr_d = {pb_q, pr_q};
                    ras_d = RST_CNT;
                    cnt_d = T_RCD_CK - 4'h1;
                    st_d = ST_RCD;
                end
            default: st_d = ST_INIT;
        endcase
        // narrow bus: upper bytes never written, upper data idle
        if (!wide_q)
        begin
            mask_d = mask_d | MASK_NARROW_OFF;
            wdat_d[DATA_W-1:NARROW_W] = '0;
        end
        // read return, sampled after the programmed latency
        rdv_d = lnk.rd_capture;
        rdat_d = rdat_q;
        if (lnk.rd_capture)
        begin
            rdat_d = mem_data_in;
            if (!wide_q)
                rdat_d[DATA_W-1:NARROW_W] = '0;
        end
    end

    // registers only; straps are caught while reset is held
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_q <= ST_INIT;
            cnt_q <= RST_CNT;
            ras_q <= RST_CNT;
            wrc_q <= CNT_SAT;
            cmd_q <= CMD_NOP;
            cs_q <= RST_CS;
            addr_q <= RST_ADDR;
            mask_q <= RST_MASK;
            wdat_q <= '0;
            oe_q <= 1'b0;
            rdv_q <= 1'b0;
            rdat_q <= '0;
            rdy_q <= 1'b0;
            done_q <= 1'b0;
            pw_q <= 1'b0;
            pb_q <= 1'b0;
            pr_q <= '0;
            pc_q <= '0;
            pd_q <= '0;
            pm_q <= RST_MASK;
            wide_q <= cfg_wide;
            lat3_q <= cfg_lat3;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            ras_q <= ras_d;
            wrc_q <= wrc_d;
            cmd_q <= cmd_d;
            cs_q <= cs_d;
            addr_q <= addr_d;
            mask_q <= mask_d;
            wdat_q <= wdat_d;
            oe_q <= oe_d;
            rdv_q <= rdv_d;
            rdat_q <= rdat_d;
            rdy_q <= rdy_d;
            done_q <= done_d;
            pw_q <= pw_d;
            pb_q <= pb_d;
            pr_q <= pr_d;
            pc_q <= pc_d;
            pd_q <= pd_d;
            pm_q <= pm_d;
            wide_q <= wide_d;
            lat3_q <= lat3_d;
        end
        cke_q <= 1'b1;
        dsf_q <= 1'b0;
    end

    assign req_ready = rdy_q;
    assign rd_valid = rdv_q;
    assign rd_data = rdat_q;
    assign mem_ready = done_q;
    assign mem_chip_select_n = cs_q;
    assign {mem_row_strobe_n, mem_column_strobe_n, mem_write_strobe_n} = cmd_q;
    assign mem_byte_mask_n = mask_q;
    assign mem_address = addr_q;
    assign mem_data_out = wdat_q;
    assign mem_data_oe = oe_q;
    assign mem_clock_enable = cke_q;
    assign special_function_select = dsf_q;

    // checks on the pin-side behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    logic [3:0] since_act_q;
    always_ff @(posedge sys_clk)
    begin
        if (rst || (cmd_q == CMD_ACT))
            since_act_q <= 4'h1;
        else if (since_act_q != CNT_SAT)
            since_act_q <= since_act_q + 4'h1;
    end

    sequence s_release;
        $fell(rst);
    endsequence
    sequence s_read_pin;
        (cmd_q == CMD_RD);
    endsequence

    a_first_cmd_pre: assert property (s_release |=> (cmd_q == CMD_PRE) && addr_q[PRE_ALL_BIT])
        else $error("first command after reset is not precharge");
    a_no_early_rw: assert property (!done_q |-> (cmd_q != CMD_RD) && (cmd_q != CMD_WR))
        else $error("read or write before mode load finished");
    a_mode_opcode: assert property ((cmd_q == CMD_LMR) |-> (addr_q[2:0] == MODE_BL_ONE)
        && (addr_q[6:4] == (lat3_q ? MODE_LAT_THREE : MODE_LAT_TWO)))
        else $error("mode opcode fields wrong");
    a_act_spacing: assert property (((cmd_q == CMD_RD) || (cmd_q == CMD_WR))
        |-> (since_act_q >= 4'h3))
        else $error("read or write too soon after activate");
    a_fixed_lines: assert property (mem_clock_enable && !special_function_select)
        else $error("clock enable or special function wrong");
    a_write_drive: assert property ((cmd_q == CMD_WR) |-> oe_q ##1 !oe_q || (cmd_q == CMD_WR))
        else $error("write data not driven with write");
    a_read_col: assert property (s_read_pin |-> !addr_q[PRE_ALL_BIT])
        else $error("read address bit 8 not zero");
    a_pre_both: assert property ((cmd_q == CMD_PRE) |-> addr_q[PRE_ALL_BIT])
        else $error("precharge without all-bank bit");
    a_read_lat2: assert property ((s_read_pin and !lat3_q) |-> ##3 rdv_q)
        else $error("latency-two read not returned");
    a_read_lat3: assert property ((s_read_pin and lat3_q) |-> ##4 rdv_q)
        else $error("latency-three read not returned");
endmodule
`default_nettype wire

// *** verif/sgfb_mem_model.sv ***
// behavioural framebuffer memory standing on the sequencer's memory pins
// assumes it shares sys_clk and the synchronous reset with the sequencer
`default_nettype none
module sgfb_mem_model
    import sgfb_pkg::*;
(
    input wire logic sys_clk, // memory clock
    input wire logic rst, // sync reset, high
    input wire logic narrow, // 64-bit build
    input wire logic lat3, // read latency three
    input wire logic [1:0] cs_n, // chip selects
    input wire logic [2:0] cmd, // row, column, write strobes
    input wire logic [MASK_W-1:0] mask_n, // byte mask
    input wire logic [ADDR_W-1:0] addr, // address
    input wire logic [DATA_W-1:0] wdata, // write data
    input wire logic oe, // write data driven
    input wire logic cke, // clock enable
    input wire logic sfs, // special function line
    output logic [DATA_W-1:0] rdata, // read data back
    output int errs // protocol faults seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] mem [int];
    logic [ROW_W-1:0] row_q [2];
    logic [1:0] open_q;
    int age [2];
    int key;
    logic pre_q, mode_q;
    logic [DATA_W-1:0] p1, p2, p3, w, sel;
    logic [DATA_W-1:0] last = 128'h0;
    logic v1 = 1'b0, v2 = 1'b0, v3 = 1'b0;
    logic [MASK_W-1:0] m1, m2;
    initial errs = 0;
    function automatic void fail(input string s);
        $display("ERROR %0t memory: %s", $time, s);
        errs++;
    endfunction
    // everything sampled on the rising edge only
    always @(posedge sys_clk)
    begin
        m1 <= mask_n;
        m2 <= m1; // read mask acts two clocks late
        {p2, p3, v2, v3} <= {p1, p2, v1, v2};
        v1 <= 1'b0;
        last <= rdata;
        age[0] = age[0] + 1;
        age[1] = age[1] + 1;
        key = {addr[BANK_BIT], row_q[addr[BANK_BIT]], addr[COL_W-1:0]};
        if (rst)
            {pre_q, mode_q, open_q} = 4'h0;
        else
        begin
            if (cke !== 1'b1 || sfs !== 1'b0) fail("clock enable");
            if (narrow ? cs_n[1] !== 1'b1 : cs_n[0] !== cs_n[1]) fail("chip select");
            if (cs_n[0] === 1'b0)
            begin
                if (!pre_q && cmd !== CMD_PRE && cmd !== CMD_NOP) fail("no precharge");
                case (cmd)
                    CMD_NOP: ;
                    CMD_PRE:
                    begin
                        if (addr[PRE_ALL_BIT] !== 1'b1) fail("precharge addr");
                        pre_q = 1'b1;
                        open_q = 2'h0;
                    end
                    CMD_LMR:
                    begin
                        if (!pre_q || addr[2:0] !== MODE_BL_ONE) fail("mode burst");
                        if (addr[6:4] !== (lat3 ? MODE_LAT_THREE : MODE_LAT_TWO))
                            fail("mode latency");
                        mode_q = 1'b1;
                    end
                    CMD_ACT:
                    begin
                        row_q[addr[BANK_BIT]] = addr[ROW_W-1:0];
                        open_q[addr[BANK_BIT]] = 1'b1;
                        age[addr[BANK_BIT]] = 0;
                    end
                    CMD_RD, CMD_WR:
                    begin
                        if (!mode_q || !open_q[addr[BANK_BIT]] || addr[PRE_ALL_BIT] !== 1'b0)
                            fail("access order");
                        if (age[addr[BANK_BIT]] < T_RCD_CK) fail("activate gap");
                        w = mem.exists(key) ? mem[key] : {8{key[15:0]}};
                        if (cmd == CMD_WR && oe !== 1'b1) fail("write data");
                        for (int b = 0; b < MASK_W; b++)
                            if (cmd == CMD_WR && !mask_n[b]) w[8*b+:8] = wdata[8*b+:8];
                        mem[key] = w;
                        p1 <= w;
                        v1 <= (cmd == CMD_RD);
                    end
                    default: fail("bad command");
                endcase
            end
        end
    end
    // floated bytes change every cycle so a stale value never passes
    assign sel = lat3 ? p3 : p2;
    always_comb
    begin
        for (int b = 0; b < MASK_W; b++)
            rdata[8*b+:8] = ((lat3 ? v3 : v2) && !m2[b]) ? sel[8*b+:8] : ~last[8*b+:8];
    end
endmodule
`default_nettype wire

// *** verif/sgfb_ctrl_tb.sv ***
// self-checking bench for the framebuffer memory command sequencer
// assumes the behavioural memory model answers on the memory pins
`default_nettype none
module sgfb_ctrl_tb;
    import sgfb_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1, cfg_wide = 1'b1, cfg_lat3 = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0, req_bank = 1'b0;
    logic [ROW_W-1:0] req_row = 9'h000;
    logic [COL_W-1:0] req_col = 8'h00;
    logic [DATA_W-1:0] req_wdata = 128'h0;
    logic [MASK_W-1:0] req_mask_n = 16'h0000;
    logic req_ready, rd_valid, mem_ready, ras_n, cas_n, we_n, oe, cke, sfs, mclk;
    logic [1:0] cs_n;
    logic [MASK_W-1:0] mask_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rd_data, dout, din;
    int n_errors = 0, checks = 0, model_errs, waits;
    logic [DATA_W-1:0] rq [$];
    // clock: 25 ns period
    always #12.5 sys_clk = ~sys_clk;
    // read data collected in arrival order
    always @(posedge sys_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
    sgfb_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .cfg_wide(cfg_wide), .cfg_lat3(cfg_lat3),
        .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank), .req_row(req_row),
        .req_col(req_col), .req_wdata(req_wdata), .req_mask_n(req_mask_n),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .mem_ready(mem_ready),
        .mem_clock_out(mclk), .mem_chip_select_n(cs_n), .mem_row_strobe_n(ras_n),
        .mem_column_strobe_n(cas_n), .mem_write_strobe_n(we_n), .mem_byte_mask_n(mask_n),
        .mem_address(addr), .mem_data_out(dout), .mem_data_oe(oe), .mem_data_in(din),
        .mem_clock_enable(cke), .special_function_select(sfs));
    sgfb_mem_model memory (.sys_clk(sys_clk), .rst(rst), .narrow(!cfg_wide), .lat3(cfg_lat3),
        .cs_n(cs_n), .cmd({ras_n, cas_n, we_n}), .mask_n(mask_n), .addr(addr), .wdata(dout),
        .oe(oe), .cke(cke), .sfs(sfs), .rdata(din), .errs(model_errs));
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic give_up(input string what);
        n_errors++;
        $display("ERROR %0t no %s in time", $time, what);
        conclude();
    endtask
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
        input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // narrow build returns only the low half
    function automatic logic [DATA_W-1:0] fit(input logic [DATA_W-1:0] d);
        return cfg_wide ? d : {64'h0, d[63:0]};
    endfunction
    task automatic boot(input logic wide, input logic lat);
        int n;
        req_valid = 1'b0;
        rst = 1'b1;
        cfg_wide = wide;
        cfg_lat3 = lat;
        tick(4);
        rst = 1'b0;
        tick(1);
        check({cs_n[0], ras_n, cas_n, we_n, addr[PRE_ALL_BIT]}, {1'b0, CMD_PRE, 1'b1},
            "first command");
        check({cke, sfs}, 2'h2, "enable lines");
        check(mclk, sys_clk, "clock forward");
        for (n = 0; n < 20 && mem_ready !== 1'b1; n++) tick(1);
        if (mem_ready !== 1'b1) give_up("init");
    endtask
    // leaves the request up so hits can follow back to back
    task automatic req(input logic w, input logic b, input logic [ROW_W-1:0] row,
        input logic [COL_W-1:0] col, input logic [DATA_W-1:0] d, input logic [MASK_W-1:0] m);
        int n;
        {req_valid, req_write, req_bank, req_row, req_col} = {1'b1, w, b, row, col};
        req_wdata = d;
        req_mask_n = m;
        for (n = 0; n < 30 && req_ready !== 1'b1; n++) tick(1);
        if (req_ready !== 1'b1) give_up("ready");
        waits += n;
        tick(1);
    endtask
    task automatic wait_reads(input int k);
        int n;
        req_valid = 1'b0;
        for (n = 0; n < 20 && rq.size() < k; n++) tick(1);
        if (rq.size() < k) give_up("read data");
    endtask
    // writes and reads to an open row every cycle, one masked
    task automatic s_hit();
        logic [DATA_W-1:0] a, c, b, e;
        a = 128'h0123456789ABCDEFFEDCBA9876543210;
        c = ~a;
        b = {8{16'hA5C3}};
        e = b;
        for (int i = 4; i < 8; i++) e[8*i+:8] = c[8*i+:8];
        rq.delete();
        req(1'b1, 1'b0, 9'h003, 8'h05, a, 16'h0000);
        req_valid = 1'b0;
        tick(6);
        waits = 0;
        req(1'b1, 1'b0, 9'h003, 8'h06, c, 16'h0000);
        req(1'b1, 1'b0, 9'h003, 8'h06, b, 16'h00F0);
        req(1'b0, 1'b0, 9'h003, 8'h05, a, 16'h0000);
        req(1'b0, 1'b0, 9'h003, 8'h06, a, 16'h0000);
        check(waits, 0, "hit stall");
        wait_reads(2);
        check(rq[0], fit(a), "read col 5");
        check(rq[1], fit(e), "masked write");
    endtask
    // row misses in one bank force precharge and a new activate
    task automatic s_miss();
        logic [DATA_W-1:0] d;
        d = {4{32'h5A0F_C396}};
        rq.delete();
        req(1'b1, 1'b1, 9'h007, 8'h09, d, 16'h0000);
        req(1'b1, 1'b1, 9'h008, 8'h09, ~d, 16'h0000);
        req(1'b0, 1'b1, 9'h007, 8'h09, d, 16'h0000);
        req(1'b0, 1'b1, 9'h008, 8'h09, d, 16'h0000);
        wait_reads(2);
        check(rq[0], fit(d), "row 7");
        check(rq[1], fit(~d), "row 8");
    endtask
    // with nothing pending only idle cycles reach the pins
    task automatic s_idle();
        req_valid = 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            tick(1);
            check({oe, rd_valid, cs_n === 2'h3 || {ras_n, cas_n, we_n} === CMD_NOP}, 3'h1,
                "idle pins");
        end
    endtask
    // main sequence: wide with latency two, then narrow with three
    initial
    begin
        boot(1'b1, 1'b0);
        s_hit();
        s_miss();
        s_idle();
        boot(1'b0, 1'b1);
        s_hit();
        s_miss();
        s_idle();
        check(model_errs, 0, "memory protocol");
        conclude();
    end
endmodule
`default_nettype wire
